// ### hdl/dcc_top.sv
/*
  Dual comparator control top: AHB-Lite register slave, input muxing
  select outputs, two channels, sync and interrupt logic.
  Assumes analog comparators outside; their decisions arrive async.
*/
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
(
  input  wire logic        hclk,          // Clock, 200 MHz
  input  wire logic        hresetn,       // Async reset, active low
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write
  input  wire logic [2:0]  hsize,         // Size
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready
  output logic      [31:0] hrdata,        // Read data
  output logic             hreadyout,     // Slave ready
  output logic             hresp,         // Response
  input  wire dcc_raw_t    cmp1_raw,      // Comparator one decisions
  input  wire dcc_raw_t    cmp2_raw,      // Comparator two decisions
  input  wire logic        timer1_clk_in, // Timer1 clock input pin
  output logic      [1:0]  cmp1_vn_sel,   // Inverting mux select
  output logic             cmp1_vp_ref,   // Non-inverting uses reference
  output logic             cmp1_power_on, // Analog enable
  output logic             cmp1_fast,     // Normal-speed mode
  output logic      [1:0]  cmp2_vn_sel,   // Inverting mux select
  output logic             cmp2_vp_ref,   // Non-inverting uses reference
  output logic             cmp2_power_on, // Analog enable
  output logic             cmp2_fast,     // Normal-speed mode
  output logic      [7:0]  analog_select, // Analog select bits
  output logic             cmp1_pin_out,  // Pin data
  output logic             cmp1_pin_oe,   // Pin output enable
  output logic             cmp2_pin_out,  // Pin data
  output logic             cmp2_pin_oe,   // Pin output enable
  output logic      [1:0]  pwm_feedback,  // Results to PWM
  output logic             timer1_gate_sel, // Timer1 gate source select
  output logic             irq            // Interrupt, active high
);

  dcc_cfg_t   cfg1_q, cfg2_q;
  logic       sync2_q, t1g_q;
  logic [7:0] ansel_q, dir_q;
  logic [1:0] irq_stat_q, irq_en_q;
  logic [7:0] addr_q;
  logic       wr_q, rd_q;
  logic [3:0] s1_a_q, s1_b_q, s1_c_q, s2_a_q, s2_b_q, s2_c_q;
  logic [3:0] f1_q, f2_q;
  logic [2:0] t1_q;
  logic       t1_rise, c2_sync_q, c2_res;
  logic       res1, res2, live1, live2, chg1, chg2;
  logic       p2_out;
  logic [1:0] clr;

  // Three-stage synchronisers; comparator change accepted when stages 2 and 3 agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_a_q <= 4'h0;
      s1_b_q <= 4'h0;
      s1_c_q <= 4'h0;
      s2_a_q <= 4'h0;
      s2_b_q <= 4'h0;
      s2_c_q <= 4'h0;
      f1_q   <= 4'h0;
      f2_q   <= 4'h0;
      t1_q   <= 3'h0;
    end else begin
      s1_a_q <= cmp1_raw.vn_below_vp;
      s1_b_q <= s1_a_q;
      s1_c_q <= s1_b_q;
      s2_a_q <= cmp2_raw.vn_below_vp;
      s2_b_q <= s2_a_q;
      s2_c_q <= s2_b_q;
      for (int i = 0; i < 4; i++) begin
        if (s1_b_q[i] == s1_c_q[i]) f1_q[i] <= s1_c_q[i];
        if (s2_b_q[i] == s2_c_q[i]) f2_q[i] <= s2_c_q[i];
      end
      t1_q <= {t1_q[1:0], timer1_clk_in};
    end
  end

  assign t1_rise = t1_q[1] & t1_q[2] ? 1'b0 : (t1_q[1] & ~t1_q[2]);

  // Analog steering from the control fields
  assign cmp1_vn_sel   = cfg1_q.channel_sel;
  assign cmp2_vn_sel   = cfg2_q.channel_sel;
  assign cmp1_vp_ref   = cfg1_q.ref_sel;
  assign cmp2_vp_ref   = cfg2_q.ref_sel;
  assign cmp1_power_on = cfg1_q.enable;
  assign cmp2_power_on = cfg2_q.enable;
  assign cmp1_fast     = cfg1_q.speed_sel;
  assign cmp2_fast     = cfg2_q.speed_sel;
  assign analog_select = ansel_q;

  dcc_channel u_ch1 (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .cfg      (cfg1_q),
    .raw_lt   (f1_q[cfg1_q.channel_sel]),
    .pin_dir  (dir_q[DCC_DIR_PIN1]),
    .result_q (res1),
    .live     (live1),
    .pin_out  (cmp1_pin_out),
    .pin_oe   (cmp1_pin_oe),
    .change   (chg1)
  );

  dcc_channel u_ch2 (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .cfg      (cfg2_q),
    .raw_lt   (f2_q[cfg2_q.channel_sel]),
    .pin_dir  (dir_q[DCC_DIR_PIN2]),
    .result_q (res2),
    .live     (live2),
    .pin_out  (p2_out),
    .pin_oe   (cmp2_pin_oe),
    .change   (chg2)
  );

  // Comparator two may be resampled on Timer1 clock rising edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) c2_sync_q <= 1'b0;
    else if (t1_rise) c2_sync_q <= res2;
  end

  assign c2_res       = sync2_q ? c2_sync_q : res2;
  assign cmp2_pin_out = sync2_q ? c2_sync_q : p2_out;
  assign pwm_feedback = {c2_res, res1};
  assign timer1_gate_sel = t1g_q;

  // AHB-Lite address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
    end else if (hready) begin
      addr_q <= haddr[7:0];
      wr_q   <= hsel & htrans[1] & hwrite;
      rd_q   <= hsel & htrans[1] & ~hwrite;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Control registers; result bit is read-only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg1_q  <= dcc_cfg_t'(7'h00);
      cfg2_q  <= dcc_cfg_t'(7'h00);
      sync2_q <= DCC_SYNC_RST[DCC_SYNC_C2S];
      t1g_q   <= DCC_SYNC_RST[DCC_SYNC_T1G];
      ansel_q <= DCC_ANSEL_RST;
      dir_q   <= DCC_DIR_RST;
      irq_en_q <= 2'h0;
    end else if (wr_q) begin
      unique case (addr_q)
        DCC_OFF_CMP1_CTRL: cfg1_q <= {hwdata[DCC_BIT_EN],
                                      hwdata[DCC_BIT_OE:DCC_BIT_CHLO]};
        DCC_OFF_CMP2_CTRL: cfg2_q <= {hwdata[DCC_BIT_EN],
                                      hwdata[DCC_BIT_OE:DCC_BIT_CHLO]};
        DCC_OFF_SYNC_CTRL: begin
          sync2_q <= hwdata[DCC_SYNC_C2S];
          t1g_q   <= hwdata[DCC_SYNC_T1G];
        end
        DCC_OFF_ANSEL:  ansel_q  <= hwdata[7:0];
        DCC_OFF_DIR:    dir_q    <= hwdata[7:0];
        DCC_OFF_IRQ_EN: irq_en_q <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // Sticky change flags; a new event wins over a clear
  assign clr = (wr_q && addr_q == DCC_OFF_IRQ_CLR) ? hwdata[1:0] : 2'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) irq_stat_q <= 2'h0;
    else irq_stat_q <= (irq_stat_q & ~clr) | {chg2, chg1};
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // Read mux; result bits reflect the latched comparator state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= 32'h0000_0000;
      unique case (haddr[7:0])
        DCC_OFF_CMP1_CTRL: hrdata[7:0] <= {cfg1_q.enable, res1,
                                           cfg1_q[5:0]};
        DCC_OFF_CMP2_CTRL: hrdata[7:0] <= {cfg2_q.enable, c2_res,
                                           cfg2_q[5:0]};
        DCC_OFF_SYNC_CTRL: hrdata[7:0] <= {res1, c2_res, 4'h0,
                                           t1g_q, sync2_q};
        DCC_OFF_ANSEL:     hrdata[7:0] <= ansel_q;
        DCC_OFF_DIR:       hrdata[7:0] <= dir_q;
        DCC_OFF_IRQ_STAT:  hrdata[1:0] <= irq_stat_q;
        DCC_OFF_IRQ_EN:    hrdata[1:0] <= irq_en_q;
        default: ;
      endcase
    end
  end

  irq_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
    chg1 |=> irq_stat_q[0]) else $error("flag not set");
  disabled_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !cfg1_q.enable [*2] |-> !res1) else $error("off result");
  ref_steer_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmp2_vp_ref == cfg2_q.ref_sel && cmp1_vn_sel == cfg1_q.channel_sel)
    else $error("steer wrong");
  speed_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmp1_fast == cfg1_q.speed_sel) else $error("speed wrong");
  pwm_feed_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !sync2_q |-> pwm_feedback == {res2, res1})
    else $error("pwm feed wrong");
  sync_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (sync2_q && !t1_rise) |=> $stable(c2_sync_q))
    else $error("sync moved");
  pin_oe_a: assert property (@(posedge hclk) disable iff (!hresetn)
    cmp1_pin_oe |-> cfg1_q.pin_drive_en) else $error("oe wrong");
  irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(irq_stat_q & irq_en_q)) else $error("irq wrong");

endmodule : dcc_top

// ### hdl/dcc_pkg.sv
/*
  Package for the dual comparator control block: register map, field
  positions, reset values and the carrier types.
  Assumes a 32-bit AHB-Lite bus, word-aligned registers.
*/
package dcc_pkg;

  localparam logic [7:0] DCC_OFF_CMP1_CTRL = 8'h00;
  localparam logic [7:0] DCC_OFF_CMP2_CTRL = 8'h04;
  localparam logic [7:0] DCC_OFF_SYNC_CTRL = 8'h08;
  localparam logic [7:0] DCC_OFF_ANSEL     = 8'h0C;
  localparam logic [7:0] DCC_OFF_DIR       = 8'h10;
  localparam logic [7:0] DCC_OFF_IRQ_STAT  = 8'h14;
  localparam logic [7:0] DCC_OFF_IRQ_CLR   = 8'h18;
  localparam logic [7:0] DCC_OFF_IRQ_EN    = 8'h1C;

  localparam int DCC_BIT_EN   = 7;
  localparam int DCC_BIT_OUT  = 6;
  localparam int DCC_BIT_OE   = 5;
  localparam int DCC_BIT_POL  = 4;
  localparam int DCC_BIT_SP   = 3;
  localparam int DCC_BIT_REF  = 2;
  localparam int DCC_BIT_CHHI = 1;
  localparam int DCC_BIT_CHLO = 0;

  localparam int DCC_SYNC_MC1 = 7;
  localparam int DCC_SYNC_MC2 = 6;
  localparam int DCC_SYNC_T1G = 1;
  localparam int DCC_SYNC_C2S = 0;

  localparam int DCC_DIR_PIN1 = 2;
  localparam int DCC_DIR_PIN2 = 4;

  localparam logic [7:0] DCC_CTRL_RST  = 8'h00;
  localparam logic [1:0] DCC_SYNC_RST  = 2'h2;
  localparam logic [7:0] DCC_ANSEL_RST = 8'hFF;
  localparam logic [7:0] DCC_DIR_RST   = 8'hFF;

  localparam logic [1:0] DCC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] DCC_HTRANS_SEQ    = 2'h3;

  // Writable configuration of one comparator
  typedef struct packed {
    logic       enable;
    logic       pin_drive_en;
    logic       invert;
    logic       speed_sel;
    logic       ref_sel;
    logic [1:0] channel_sel;
  } dcc_cfg_t;

  // Raw analog comparator decisions, one per channel / reference choice
  typedef struct packed {
    logic [3:0] vn_below_vp;
  } dcc_raw_t;

endpackage : dcc_pkg

// ### hdl/dcc_channel.sv
/*
  One comparator channel: polarity, per-cycle latch, change detect and
  pin gating.
  Assumes raw analog decisions already synchronised to hclk.
*/
`timescale 1ns/1ps
module dcc_channel
  import dcc_pkg::*;
(
  input  wire logic     hclk,      // Clock
  input  wire logic     hresetn,   // Async reset, active low
  input  wire dcc_cfg_t cfg,       // Control fields
  input  wire logic     raw_lt,    // Selected VN below selected VP
  input  wire logic     pin_dir,   // Port direction bit, 0 = output
  output logic          result_q,  // Latched result
  output logic          live,      // Unlatched result
  output logic          pin_out,   // Pin data
  output logic          pin_oe,    // Pin output enable
  output logic          change     // Latched result changed
);

  logic prev_q;

  // Disabled comparator presents zero
  assign live = cfg.enable & (raw_lt ^ cfg.invert);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_q <= 1'b0;
      prev_q   <= 1'b0;
    end else begin
      result_q <= live;
      prev_q   <= result_q;
    end
  end

  // Change and pin data independent of pin_drive_en; pin_oe gated by it
  assign change  = result_q ^ prev_q;
  assign pin_out = live;
  assign pin_oe  = cfg.pin_drive_en & cfg.enable & ~pin_dir;

  pin_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    pin_oe |-> (cfg.enable && !pin_dir)) else $error("pin driven off");
  latch_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 result_q == $past(live)) else $error("latch lag wrong");
  change_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (result_q != $past(result_q)) |-> change)
    else $error("change missed");

endmodule : dcc_channel

// ### bench/dcc_top_test.sv
/*
  Self-checking bench for the dual comparator control block.
  Assumes dcc_pkg and dcc_top compiled first; bus answers with zero wait.
*/
`timescale 1ns/1ps
module dcc_top_test;
  import dcc_pkg::*;
  typedef struct {
    logic [31:0] exp;
    logic [31:0] mask;
  } dcc_note_t;
  logic        hclk, hresetn, hsel, hwrite, timer1_clk_in, rd_dp;
  logic [31:0] haddr, hwdata, hrdata, obs1, obs2, seed;
  logic [1:0]  htrans, probe, cmp1_vn_sel, cmp2_vn_sel, pwm_feedback;
  logic [2:0]  hsize;
  logic [7:0]  analog_select;
  logic        hreadyout, hresp, irq, timer1_gate_sel;
  logic        cmp1_vp_ref, cmp1_power_on, cmp1_fast, cmp1_pin_out, cmp1_pin_oe;
  logic        cmp2_vp_ref, cmp2_power_on, cmp2_fast, cmp2_pin_out, cmp2_pin_oe;
  dcc_raw_t    cmp1_raw, cmp2_raw;
  dcc_note_t   notes[$];
  int          fails, checked;
  logic [1:0]  res;

  dcc_top i_dcc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cmp1_raw(cmp1_raw),
    .cmp2_raw(cmp2_raw), .timer1_clk_in(timer1_clk_in),
    .cmp1_vn_sel(cmp1_vn_sel), .cmp1_vp_ref(cmp1_vp_ref),
    .cmp1_power_on(cmp1_power_on), .cmp1_fast(cmp1_fast),
    .cmp2_vn_sel(cmp2_vn_sel), .cmp2_vp_ref(cmp2_vp_ref),
    .cmp2_power_on(cmp2_power_on), .cmp2_fast(cmp2_fast),
    .analog_select(analog_select), .cmp1_pin_out(cmp1_pin_out),
    .cmp1_pin_oe(cmp1_pin_oe), .cmp2_pin_out(cmp2_pin_out),
    .cmp2_pin_oe(cmp2_pin_oe), .pwm_feedback(pwm_feedback),
    .timer1_gate_sel(timer1_gate_sel), .irq(irq));

  assign obs1 = {23'h0, irq, cmp1_vn_sel, cmp1_vp_ref, cmp1_power_on,
                 cmp1_fast, cmp1_pin_oe, cmp1_pin_out, pwm_feedback[0]};
  assign obs2 = {23'h0, irq, cmp2_vn_sel, cmp2_vp_ref, cmp2_power_on,
                 cmp2_fast, cmp2_pin_oe, cmp2_pin_out, pwm_feedback[1]};

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic results();
    if (fails == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  // Bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) fails++;
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= DCC_HTRANS_NONSEQ;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp  <= ~wr;
    wait_ready();
    rd_dp  <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back('{e, 32'hFFFFFFFF});
    bus(1'b0, a, 32'h00000000);
  endtask : rd

  task automatic chk(input logic [1:0] src, input logic [31:0] e,
                     input logic [31:0] m);
    notes.push_back('{e, m});
    probe <= src;
    @(posedge hclk);
    probe <= 2'h0;
    @(posedge hclk);
  endtask : chk

  // Compares the oldest note with whatever result shows at this edge
  always @(posedge hclk) begin
    dcc_note_t   nt;
    logic [31:0] act;
    if ((rd_dp && hreadyout) || probe != 2'h0) begin
      nt = notes.pop_front();
      act = rd_dp ? hrdata : (probe == 2'h1 ? obs1 : obs2);
      checked++;
      if (((act & nt.mask) !== (nt.exp & nt.mask)) || hresp !== 1'b0) begin
        fails++;
        $display("unexpected at %0t: got %h expected %h", $time, act, nt.exp);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    results();
  end

  initial begin
    logic       en, oe, dir, inv, sp, rf, r, drv;
    logic [1:0] ch;
    logic [3:0] v;
    logic [7:0] off;
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = '0; timer1_clk_in = 1'b0; rd_dp = 1'b0;
    probe = 2'h0; cmp1_raw = '0; cmp2_raw = '0; fails = 0; checked = 0;
    seed = 32'h0000F1B4; res = 2'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(DCC_OFF_CMP1_CTRL, 32'h00000000);
    rd(DCC_OFF_CMP2_CTRL, 32'h00000000);
    rd(DCC_OFF_SYNC_CTRL, 32'h00000002);
    rd(DCC_OFF_ANSEL, 32'h000000FF);
    rd(DCC_OFF_DIR, 32'h000000FF);
    rd(DCC_OFF_IRQ_EN, 32'h00000000);
    bus(1'b1, 8'h20, 32'h000000FF);
    rd(8'h20, 32'h00000000);
    bus(1'b1, DCC_OFF_ANSEL, 32'h000000FF);
    for (int n = 0; n < 2; n++) begin
      off = n ? DCC_OFF_CMP2_CTRL : DCC_OFF_CMP1_CTRL;
      for (int k = 0; k < 16; k++) begin
        ch = k[1:0]; inv = k[2]; en = (k % 5) != 4; oe = k[0] ^ k[3];
        dir = k[3] & ~k[1]; sp = k[1] ^ k[2]; rf = k[0] ^ k[2];
        seed = rnd();
        v = seed[3:0];
        if (n == 0) cmp1_raw.vn_below_vp <= v;
        else cmp2_raw.vn_below_vp <= v;
        r = en & (v[ch] ^ inv);
        drv = oe & en & ~dir;
        res[n] = r;
        bus(1'b1, DCC_OFF_DIR, dir ? 32'h000000FF : 32'h00000000);
        bus(1'b1, off, {24'h0, en, 1'b1, oe, inv, sp, rf, ch});
        repeat (8) @(posedge hclk);
        rd(off, {24'h0, en, r, oe, inv, sp, rf, ch});
        rd(DCC_OFF_SYNC_CTRL, {24'h0, res[0], res[1], 6'h02});
        chk(n + 1, {24'h0, ch, rf, en, sp, drv, r, r},
            {24'h0, 6'h3F, drv, 1'b1});
      end
    end
    bus(1'b1, DCC_OFF_CMP1_CTRL, 32'h00000080);
    cmp1_raw.vn_below_vp <= 4'h0;
    bus(1'b1, DCC_OFF_IRQ_EN, 32'h00000003);
    repeat (8) @(posedge hclk);
    bus(1'b1, DCC_OFF_IRQ_CLR, 32'h00000003);
    bus(1'b1, DCC_OFF_IRQ_STAT, 32'h00000003);
    rd(DCC_OFF_IRQ_STAT, 32'h00000000);
    rd(DCC_OFF_IRQ_CLR, 32'h00000000);
    chk(2'h1, 32'h00000000, 32'h00000100);
    for (int k = 0; k < 2; k++) begin
      cmp1_raw.vn_below_vp <= k ? 4'h0 : 4'hF;
      repeat (8) @(posedge hclk);
      rd(DCC_OFF_IRQ_STAT, 32'h00000001);
      chk(2'h1, 32'h00000100, 32'h00000100);
      bus(1'b1, DCC_OFF_IRQ_EN, 32'h00000002);
      chk(2'h1, 32'h00000000, 32'h00000100);
      bus(1'b1, DCC_OFF_IRQ_EN, 32'h00000003);
      chk(2'h1, 32'h00000100, 32'h00000100);
      bus(1'b1, DCC_OFF_IRQ_CLR, 32'h00000001);
      rd(DCC_OFF_IRQ_STAT, 32'h00000000);
      chk(2'h1, 32'h00000000, 32'h00000100);
    end
    // Sync on: comparator two result held until a Timer1 clock rise
    bus(1'b1, DCC_OFF_SYNC_CTRL, 32'h00000001);
    repeat (4) @(posedge hclk);
    rd(DCC_OFF_SYNC_CTRL, 32'h00000001);
    timer1_clk_in <= 1'b1;
    repeat (8) @(posedge hclk);
    timer1_clk_in <= 1'b0;
    repeat (4) @(posedge hclk);
    rd(DCC_OFF_SYNC_CTRL, {24'h0, 1'b0, res[1], 6'h01});
    repeat (4) @(posedge hclk);
    results();
  end
endmodule : dcc_top_test
